// ### chain_msg_defines.svh
// constants for the daisy-chain message layer: offsets, fields, codes, timing
// assumes nothing of its includer
`ifndef CHAIN_MSG_DEFINES_SVH
`define CHAIN_MSG_DEFINES_SVH

// ----------------------------------------
// clock and timing
// ----------------------------------------
`define CLK_PERIOD_NS     25
`define LEG_DELAY_NS      2000
`define LEG_DELAY_CYC     ((`LEG_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ----------------------------------------
// checksum
// ----------------------------------------
`define CRC_POLY_KOOP     16'h9eb2
`define CRC_POLY          16'h3d65  // msb-first form
`define CRC_SEED          16'h0000

// ----------------------------------------
// message fields and codes
// ----------------------------------------
`define CMD_NOP           2'h0
`define CMD_RD            2'h1
`define CMD_WR            2'h2
`define NODE_BCAST        6'h3f
`define NODE_INIT         6'h00
`define WAKE_WORD         16'hffee
`define WAKE_CHAIN        3'h7
`define WAKE_SEQ          4'hf
`define WAKE_LEN          2'h3
`define WAKE_REG          14'h3fff
`define FILL_OK           16'h0000
`define FILL_ERR          16'h8000
`define MSG_MIN_BITS      8'h40

// ----------------------------------------
// register map, byte addresses
// ----------------------------------------
`define OFS_CTRL          4'h0
`define OFS_STAT          4'h4
`define OFS_ERRCNT        4'h8
`define CTRL_RST          32'h0000_0000
`define BIT_PAD           6
`define BIT_SLEEP         9
`define BIT_CRCF          0
`define BIT_SUMF          1
`endif

// ### chain_msg_pkg.sv
// types shared by the daisy-chain message layer
// assumes the defines header is compiled alongside
package chain_msg_pkg;
	// transmit sequencer, gray coded in declaration order
	typedef enum logic [2:0] {
		TX_IDLE   = 3'b000,
		TX_HDR    = 3'b001,
		TX_DAT    = 3'b011,
		TX_CRC    = 3'b010,
		TX_CLOSE  = 3'b110,
		TX_LOPEN  = 3'b111,
		TX_LWAIT  = 3'b101,
		TX_LCLOSE = 3'b100
	} tx_state_e;
endpackage

// ### chain_msg_layer.sv
// message layer of a two-port daisy-chain node: checksum, multiread replies, wake
// assumes a bit-level link phy with symbol strobes and a register source
//
// Behaviour
// - transmit checksum over header and data bits
// - checksum fills the frame's lowest sixteen bits
// - accept frame only if remainder is zero
// - bad remainder drops frame, flags, counts error
// - any link fault raises the summary fault
// - multiread split into messages of chunk length
// - no padding: last message carries remainder only
// - padding: last message filled with zero words
// - access error fills with error word instead
// - length field counts padded words too
// - no-operation messages cause no action
// - wake is broadcast 64-bit nop with pattern
// - wake ignores chain, leader, length, sequence
// - only first wake after activation wakes system
// - generated wake uses fixed header and pattern
// - per-port wake format, one legacy port
// - legacy wake is open, delay, close
// - two ports, six-bit node address
// - node address zero reserved for initialisation
// - all-ones node address means broadcast
// - frames bounded by open and close symbols
// - any link activity leaves low power
// - execute own or broadcast, echo chain field
// - broadcast reads are ignored
`timescale 1ns/100ps
`include "chain_msg_defines.svh"

module chain_msg_layer
	import chain_msg_pkg::*;
#(
	parameter int ERRCNT_W  = 8,
	parameter int LEG_DLY   = `LEG_DELAY_CYC
) (
	input  wire logic        i_core_clk,
	input  wire logic        i_rst_n,
	// avalon-mm slave
	input  wire logic [3:0]  i_address,
	input  wire logic        i_read,
	input  wire logic        i_write,
	input  wire logic [31:0] i_writedata,
	output logic      [31:0] o_readdata,
	output logic             o_waitrequest,
	// receive side of the link
	input  wire logic        i_rx_activity,
	input  wire logic        i_rx_open,
	input  wire logic        i_rx_bit_valid,
	input  wire logic        i_rx_bit,
	input  wire logic        i_rx_close,
	// transmit side of the link
	output logic [1:0]       o_tx_port,
	output logic             o_tx_open,
	output logic             o_tx_bit_valid,
	output logic             o_tx_bit,
	output logic             o_tx_close,
	// register source for replies
	output logic [13:0]      o_reg_rd_addr,
	input  wire logic [15:0] i_reg_rdata,
	input  wire logic        i_access_err,
	// write command handoff
	output logic             o_cmd_wr_valid,
	output logic [13:0]      o_cmd_wr_addr,
	output logic [15:0]      o_cmd_wr_data,
	// system state
	output logic             o_active,
	output logic             o_sys_wake,
	output logic             o_link_fault
);

	// ----------------------------------------
	// elaboration checks
	// ----------------------------------------
	if (ERRCNT_W < 1 || ERRCNT_W > 32) begin : g_bad_cnt
		$error("error counter width out of range");
	end
	if (LEG_DLY < 1 || LEG_DLY > 65535) begin : g_bad_dly
		$error("legacy wake delay out of range");
	end

	// serial checksum step, msb first, no final inversion
	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
		logic fb;
		fb = c[15] ^ b;
		crc_step = {c[14:0], 1'b0} ^ (fb ? `CRC_POLY : 16'h0000);
	endfunction

	// ----------------------------------------
	// register file
	// ----------------------------------------
	logic [31:0]         ctrl_reg;      // node address, pad, wake formats
	logic                crcf_reg;      // checksum_fail_flag
	logic                sumf_reg;      // link_fault_summary
	logic [ERRCNT_W-1:0] errcnt_reg;    // link_error_counter
	logic                wait_reg;      // waitrequest, high while idle
	logic                wake_seen_reg; // first wake after activation taken

	wire [5:0] own_node_address  = ctrl_reg[5:0];  // init address until set
	wire       pad_en            = ctrl_reg[`BIT_PAD];
	wire [1:0] wake_format_select = ctrl_reg[8:7];

	// bus decode; a request is answered on the second edge
	wire bus_req = i_read | i_write;
	wire bus_go  = bus_req & ~wait_reg;
	wire wr_go   = i_write & ~wait_reg;
	wire wr_ctrl = wr_go & (i_address == `OFS_CTRL);
	wire wr_stat = wr_go & (i_address == `OFS_STAT);
	wire wr_cnt  = wr_go & (i_address == `OFS_ERRCNT);
	wire sleep   = wr_ctrl & i_writedata[`BIT_SLEEP];

	// ----------------------------------------
	// receive path
	// ----------------------------------------
	logic [15:0] rx_crc_reg;   // running remainder over the whole frame
	logic [31:0] rx_sh_reg;    // last bits received
	logic [31:0] rx_hdr_reg;   // header captured after 32 bits
	logic [15:0] rx_dat_reg;   // first data word
	logic [7:0]  rx_cnt_reg;   // bits in frame, saturating
	logic        rx_in_reg;    // inside a frame

	wire [1:0]  f_cmd  = rx_hdr_reg[31:30];
	wire        f_leader_select_field = rx_hdr_reg[29];
	wire [2:0]  f_chain_number_field = rx_hdr_reg[28:26];
	wire [5:0]  f_node = rx_hdr_reg[25:20];
	wire [3:0]  f_seq  = rx_hdr_reg[19:16];
	wire [13:0] f_reg  = rx_hdr_reg[13:0];

	// checksum over all bits including the trailer must be zero
	wire rx_done  = i_rx_close & rx_in_reg;
	wire crc_ok   = (rx_crc_reg == `CRC_SEED) && (rx_cnt_reg >= `MSG_MIN_BITS);
	wire crc_bad  = rx_done & ~crc_ok;

	// tx busy means a reply or wake message is pending: new frames are ignored meanwhile
	logic tx_busy;
	wire  accept  = rx_done & crc_ok & ~tx_busy;
	wire  is_bc   = (f_node == `NODE_BCAST);
	wire  is_own  = (f_node == own_node_address);
	// wake match ignores chain, leader, length and sequence fields
	wire  is_wake = (f_cmd == `CMD_NOP) && is_bc && (rx_cnt_reg == `MSG_MIN_BITS)
	                && (rx_dat_reg == `WAKE_WORD);
	wire  wake_go = accept & is_wake & ~wake_seen_reg & o_active;
	// reads to the broadcast address would collide, so they are dropped
	wire  rd_go   = accept & (f_cmd == `CMD_RD) & is_own & ~is_bc
	                & (rx_dat_reg[7:0] != 8'h00);
	wire  wr_cmd  = accept & (f_cmd == `CMD_WR) & (is_own | is_bc);

	// shift and checksum every received bit
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			rx_crc_reg <= 16'h0000;
			rx_sh_reg  <= 32'h0000_0000;
			rx_cnt_reg <= 8'h00;
			rx_in_reg  <= 1'b0;
		end else if (i_rx_open) begin
			rx_crc_reg <= `CRC_SEED;
			rx_cnt_reg <= 8'h00;
			rx_in_reg  <= 1'b1;
		end else if (i_rx_bit_valid && rx_in_reg) begin
			rx_crc_reg <= crc_step(rx_crc_reg, i_rx_bit);
			rx_sh_reg  <= {rx_sh_reg[30:0], i_rx_bit};
			rx_cnt_reg <= (rx_cnt_reg == 8'hff) ? rx_cnt_reg : rx_cnt_reg + 8'h01;
		end else if (i_rx_close) begin
			rx_in_reg  <= 1'b0;
		end
	end

	// capture header and first data word as they pass
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			rx_hdr_reg <= 32'h0000_0000;
			rx_dat_reg <= 16'h0000;
		end else if (i_rx_bit_valid && rx_in_reg) begin
			if (rx_cnt_reg == 8'd31)
				rx_hdr_reg <= {rx_sh_reg[30:0], i_rx_bit};
			if (rx_cnt_reg == 8'd47)
				rx_dat_reg <= {rx_sh_reg[14:0], i_rx_bit};
		end
	end

	// ----------------------------------------
	// fault flags, counter and power state
	// ----------------------------------------
	// the hardware set wins over a software clear in the same cycle
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			crcf_reg   <= 1'b0;
			sumf_reg   <= 1'b0;
			errcnt_reg <= '0;
		end else begin
			crcf_reg   <= crc_bad | (crcf_reg & ~(wr_stat & i_writedata[`BIT_CRCF]));
			sumf_reg   <= crc_bad | (sumf_reg & ~(wr_stat & i_writedata[`BIT_SUMF]));
			if (crc_bad)
				errcnt_reg <= errcnt_reg + 1'b1;
			else if (wr_cnt)
				errcnt_reg <= '0;
		end
	end

	// any link activity wakes the node, software puts it back to sleep
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			o_active      <= 1'b0;
			wake_seen_reg <= 1'b0;
			o_sys_wake    <= 1'b0;
			o_link_fault  <= 1'b0;
		end else begin
			o_active      <= i_rx_activity | i_rx_open | (o_active & ~sleep);
			wake_seen_reg <= wake_go | (wake_seen_reg & ~sleep);
			o_sys_wake    <= wake_go;
			o_link_fault  <= crc_bad | (sumf_reg & ~(wr_stat & i_writedata[`BIT_SUMF]));
		end
	end

	// write commands are handed on; nop frames do nothing
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			o_cmd_wr_valid <= 1'b0;
			o_cmd_wr_addr  <= 14'h0000;
			o_cmd_wr_data  <= 16'h0000;
		end else begin
			o_cmd_wr_valid <= wr_cmd;
			if (wr_cmd) begin
				o_cmd_wr_addr <= f_reg;
				o_cmd_wr_data <= rx_dat_reg;
			end
		end
	end

	// ----------------------------------------
	// avalon slave
	// ----------------------------------------
	wire [31:0] stat_val = {27'h0, tx_busy, wake_seen_reg, o_active, sumf_reg, crcf_reg};
	wire [31:0] rd_val   = (i_address == `OFS_CTRL)   ? ctrl_reg :
	                       (i_address == `OFS_STAT)   ? stat_val :
	                       (i_address == `OFS_ERRCNT) ? 32'(errcnt_reg) : 32'h0000_0000;

	// one wait state: read data is loaded while waitrequest is high
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			wait_reg   <= 1'b1;
			o_readdata <= 32'h0000_0000;
			ctrl_reg   <= `CTRL_RST;
		end else begin
			wait_reg <= ~(bus_req & wait_reg);
			if (i_read && wait_reg)
				o_readdata <= rd_val;
			if (wr_ctrl)
				ctrl_reg <= {22'h0, 1'b0, i_writedata[8:0]};  // sleep is a pulse
		end
	end
	assign o_waitrequest = wait_reg;

	// ----------------------------------------
	// transmit sequencer
	// ----------------------------------------
	tx_state_e   st_reg;
	logic [31:0] sh_reg;      // outgoing header or data word
	logic [15:0] tcrc_reg;    // outgoing remainder
	logic [4:0]  bit_reg;     // bit within header or word
	logic [2:0]  widx_reg;    // word within message
	logic [2:0]  words_reg;   // words in this message incl. padding
	logic [2:0]  real_reg;    // words carrying register data
	logic [7:0]  left_reg;    // registers still owed
	logic [1:0]  chunk_reg;   // response_chunk_length code
	logic        err_reg;     // reply reports an access error
	logic [3:0]  echo_reg;    // leader and chain echo
	logic [3:0]  eseq_reg;
	logic        wk_pend_reg; // wake message owed
	logic        wk_msg_reg;  // message in flight is a wake
	logic        leg_done_reg;
	logic [15:0] dly_reg;

	// only one port may be legacy; port 0 wins if both are set
	wire [1:0] leg_port = wake_format_select[0] ? 2'b01 : wake_format_select[1] ? 2'b10 : 2'b00;
	wire [2:0] chunk_w  = {1'b0, chunk_reg} + 3'd1;
	wire [2:0] take_w   = (left_reg < 8'(chunk_w)) ? left_reg[2:0] : chunk_w;
	// padding keeps the chunk length, otherwise the last one shrinks
	wire [2:0] send_w   = pad_en ? chunk_w : take_w;
	wire [15:0] fill_w  = err_reg ? `FILL_ERR : `FILL_OK;
	wire [2:0] nidx     = widx_reg + 3'd1;
	wire [15:0] word_w  = wk_msg_reg ? `WAKE_WORD : (nidx < real_reg) ? i_reg_rdata : fill_w;
	wire [15:0] word0_w = wk_msg_reg ? `WAKE_WORD : (real_reg != 3'd0) ? i_reg_rdata : fill_w;
	wire [1:0] len_w    = 2'(send_w - 3'd1);
	wire [31:0] rsp_hdr = {`CMD_RD, echo_reg, own_node_address, eseq_reg, len_w, o_reg_rd_addr};
	wire [31:0] wk_hdr  = {`CMD_NOP, 1'b0, `WAKE_CHAIN, `NODE_BCAST, `WAKE_SEQ, `WAKE_LEN,
	                       `WAKE_REG};
	wire emit = (st_reg == TX_HDR) || (st_reg == TX_DAT);
	assign tx_busy = (st_reg != TX_IDLE) || (left_reg != 8'h00) || wk_pend_reg;

	// reply bookkeeping, loaded when a read is accepted
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			chunk_reg <= 2'h0;
			err_reg   <= 1'b0;
			echo_reg  <= 4'h0;
			eseq_reg  <= 4'h0;
		end else if (rd_go) begin
			chunk_reg <= rx_dat_reg[9:8];
			err_reg   <= i_access_err;
			echo_reg  <= {f_leader_select_field, f_chain_number_field};
			eseq_reg  <= f_seq;
		end
	end

	// bit output and checksum; header and data feed the remainder
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			o_tx_bit       <= 1'b0;
			o_tx_bit_valid <= 1'b0;
			tcrc_reg       <= `CRC_SEED;
		end else begin
			o_tx_bit_valid <= emit || (st_reg == TX_CRC);
			if (st_reg == TX_IDLE) begin
				tcrc_reg <= `CRC_SEED;
			end else if (emit) begin
				o_tx_bit <= sh_reg[31];
				tcrc_reg <= crc_step(tcrc_reg, sh_reg[31]);
			end else if (st_reg == TX_CRC) begin
				o_tx_bit <= tcrc_reg[15];
				tcrc_reg <= {tcrc_reg[14:0], 1'b0};
			end
		end
	end

	// message sequencing: header, words, checksum, close
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			st_reg        <= TX_IDLE;
			sh_reg        <= 32'h0000_0000;
			bit_reg       <= 5'h00;
			widx_reg      <= 3'h0;
			words_reg     <= 3'h0;
			real_reg      <= 3'h0;
			left_reg      <= 8'h00;
			wk_pend_reg   <= 1'b0;
			wk_msg_reg    <= 1'b0;
			leg_done_reg  <= 1'b0;
			dly_reg       <= 16'h0000;
			o_reg_rd_addr <= 14'h0000;
			o_tx_port     <= 2'b00;
			o_tx_open     <= 1'b0;
			o_tx_close    <= 1'b0;
		end else begin
			o_tx_open  <= 1'b0;
			o_tx_close <= 1'b0;
			bit_reg    <= bit_reg + 5'h01;
			if (emit)
				sh_reg <= {sh_reg[30:0], 1'b0};
			case (st_reg)
				TX_IDLE: begin
					bit_reg <= 5'h00;
					if (rd_go) begin
						left_reg      <= rx_dat_reg[7:0];
						o_reg_rd_addr <= f_reg;
					end else if (wake_go) begin
						wk_pend_reg  <= 1'b1;
						leg_done_reg <= 1'b0;
					end else if (left_reg != 8'h00) begin
						// replies leave on both ports
						st_reg     <= TX_HDR;
						sh_reg     <= rsp_hdr;
						words_reg  <= send_w;
						real_reg   <= take_w;
						wk_msg_reg <= 1'b0;
						o_tx_port  <= 2'b11;
						o_tx_open  <= 1'b1;
					end else if (wk_pend_reg && leg_port != 2'b00 && !leg_done_reg) begin
						st_reg    <= TX_LOPEN;
						o_tx_port <= leg_port;
					end else if (wk_pend_reg && leg_port != 2'b11) begin
						st_reg     <= TX_HDR;
						sh_reg     <= wk_hdr;
						words_reg  <= 3'd1;
						real_reg   <= 3'd0;
						wk_msg_reg <= 1'b1;
						o_tx_port  <= ~leg_port;
						o_tx_open  <= 1'b1;
					end else begin
						wk_pend_reg <= 1'b0;
					end
				end
				TX_HDR: begin
					if (bit_reg == 5'd31) begin
						st_reg   <= TX_DAT;
						bit_reg  <= 5'h00;
						widx_reg <= 3'h0;
						sh_reg   <= {word0_w, 16'h0000};
						if (real_reg != 3'd0)
							o_reg_rd_addr <= o_reg_rd_addr + 14'h0001;
					end
				end
				TX_DAT: begin
					if (bit_reg == 5'd15) begin
						bit_reg <= 5'h00;
						if (nidx < words_reg) begin
							widx_reg <= nidx;
							sh_reg   <= {word_w, 16'h0000};
							if (nidx < real_reg)
								o_reg_rd_addr <= o_reg_rd_addr + 14'h0001;
						end else begin
							st_reg <= TX_CRC;
						end
					end
				end
				TX_CRC: begin
					if (bit_reg == 5'd15)
						st_reg <= TX_CLOSE;
				end
				TX_CLOSE: begin
					o_tx_close <= 1'b1;
					st_reg     <= TX_IDLE;
					if (wk_msg_reg)
						wk_pend_reg <= 1'b0;
					else
						left_reg <= left_reg - 8'(real_reg);
				end
				// legacy wake: open symbol, pause, close symbol
				TX_LOPEN: begin
					o_tx_open <= 1'b1;
					dly_reg   <= 16'(LEG_DLY);
					st_reg    <= TX_LWAIT;
				end
				TX_LWAIT: begin
					dly_reg <= dly_reg - 16'h0001;
					if (dly_reg == 16'h0001)
						st_reg <= TX_LCLOSE;
				end
				TX_LCLOSE: begin
					o_tx_close   <= 1'b1;
					leg_done_reg <= 1'b1;
					st_reg       <= TX_IDLE;
				end
				default: st_reg <= TX_IDLE;
			endcase
		end
	end

endmodule

// ### chain_reg_source.sv
// register source standing behind the reply path of the message layer
// assumes the layer reads data combinationally
`timescale 1ns/100ps
module chain_reg_source (
	input  wire logic [13:0] i_reg_addr,  // index driven by the layer
	input  wire logic        i_err_mode,  // bench asks for an access error
	output logic      [15:0] o_reg_rdata, // data for that index
	output logic             o_access_err // access error seen by the layer
);
	// data carries its own index, so a skipped or repeated word shows up
	assign o_reg_rdata  = {2'h2, i_reg_addr};
	assign o_access_err = i_err_mode;
endmodule

// ### chain_msg_layer_chk.sv
// concurrent checks on the ports of the message layer
// assumes one clock domain with a synchronous active-low reset
`timescale 1ns/100ps
`include "chain_msg_defines.svh"
module chain_msg_layer_chk (
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic i_read,
	input wire logic i_write,
	input wire logic i_rx_activity,
	input wire logic i_rx_close,
	input wire logic o_waitrequest,
	input wire logic o_tx_open,
	input wire logic o_tx_bit_valid,
	input wire logic o_tx_bit,
	input wire logic o_sys_wake,
	input wire logic o_active,
	input wire logic o_link_fault,
	input wire logic o_cmd_wr_valid,
	input wire logic o_tx_close
);
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);
	logic [7:0]  run_q;  // bits sent in the current message
	logic [15:0] crc_q;  // running remainder over every sent bit
	logic        woke_q; // a system wake already happened while active
	// ----------------------------------------
	// helper state; bit count and remainder restart at each open symbol
	// ----------------------------------------
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n || o_tx_open) begin
			run_q <= 8'h00;
			crc_q <= 16'h0000;
		end else if (o_tx_bit_valid) begin
			run_q <= run_q + 8'h01;
			crc_q <= {crc_q[14:0], 1'b0} ^ ((crc_q[15] ^ o_tx_bit) ? `CRC_POLY : 16'h0);
		end
	end
	// wake memory forgets once the node leaves active mode
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n || !o_active) woke_q <= 1'b0;
		else if (o_sys_wake) woke_q <= 1'b1;
	end
	property p_wait_answer; (i_read || i_write) && o_waitrequest |=> !o_waitrequest; endproperty
	a_wait_answer: assert property (p_wait_answer) else $error("bus request got no answer");
	property p_wait_pulse; !o_waitrequest |=> o_waitrequest; endproperty
	a_wait_pulse: assert property (p_wait_pulse) else $error("waitrequest low too long");
	property p_first_bit; $rose(o_tx_bit_valid) |-> $past(o_tx_open); endproperty
	a_first_bit: assert property (p_first_bit) else $error("bits without open");
	property p_close_after; $fell(o_tx_bit_valid) |-> o_tx_close; endproperty
	a_close_after: assert property (p_close_after) else $error("no close");
	property p_frame_len; $fell(o_tx_bit_valid) |-> run_q >= 8'd64 && run_q[3:0] == 4'h0; endproperty
	a_frame_len: assert property (p_frame_len) else $error("bad length");
	property p_crc_zero; $fell(o_tx_bit_valid) |-> crc_q == 16'h0000; endproperty
	a_crc_zero: assert property (p_crc_zero) else $error("bad checksum");
	property p_activity; i_rx_activity |=> o_active; endproperty
	a_activity: assert property (p_activity) else $error("activity left node asleep");
	property p_wake_once; o_sys_wake |-> !woke_q; endproperty
	a_wake_once: assert property (p_wake_once) else $error("second system wake");
	property p_wake_cause; o_sys_wake |-> $past(i_rx_close); endproperty
	a_wake_cause: assert property (p_wake_cause) else $error("wake without frame");
	property p_fault_cause; $rose(o_link_fault) |-> $past(i_rx_close); endproperty
	a_fault_cause: assert property (p_fault_cause) else $error("stray fault");
	property p_wr_cause; o_cmd_wr_valid |-> $past(i_rx_close); endproperty
	a_wr_cause: assert property (p_wr_cause) else $error("write without frame");
endmodule
bind chain_msg_layer chain_msg_layer_chk chk_u (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
	.i_read(i_read), .i_write(i_write), .i_rx_activity(i_rx_activity), .i_rx_close(i_rx_close),
	.o_waitrequest(o_waitrequest), .o_tx_open(o_tx_open), .o_tx_bit_valid(o_tx_bit_valid),
	.o_tx_bit(o_tx_bit), .o_sys_wake(o_sys_wake), .o_active(o_active),
	.o_link_fault(o_link_fault), .o_cmd_wr_valid(o_cmd_wr_valid), .o_tx_close(o_tx_close));

// ### tb.sv
// self-checking bench for the daisy-chain message layer
// assumes the register source model feeds reply data
`timescale 1ns/100ps
`include "chain_msg_defines.svh"
module tb;
	logic         clk, rst_n, rd, wr, rx_act, rx_open, rx_bv, rx_bit, rx_close, err_mode;
	logic         wreq, tx_open, tx_bv, tx_bit, tx_close, wr_v, active, sys_wake, fault, aerr;
	logic [3:0]   addr;
	logic [31:0]  wdata, rdata, q;
	logic [1:0]   tx_port;
	logic [13:0]  reg_addr, wr_a;
	logic [15:0]  reg_rdata, wr_d;
	logic [127:0] cur_w;
	logic [127:0] mdat[$];  // finished messages, right aligned
	int           mlen[$];  // bit count of each message
	logic [1:0]   mport[$]; // ports of each message
	int           err_total, n_compared, wr_n, wake_n, cur_n, n0;
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	chain_msg_layer #(.LEG_DLY(3)) dut_u (.i_core_clk(clk), .i_rst_n(rst_n), .i_address(addr),
		.i_read(rd), .i_write(wr), .i_writedata(wdata), .o_readdata(rdata),
		.o_waitrequest(wreq), .i_rx_activity(rx_act), .i_rx_open(rx_open),
		.i_rx_bit_valid(rx_bv), .i_rx_bit(rx_bit), .i_rx_close(rx_close), .o_tx_port(tx_port),
		.o_tx_open(tx_open), .o_tx_bit_valid(tx_bv), .o_tx_bit(tx_bit), .o_tx_close(tx_close),
		.o_reg_rd_addr(reg_addr), .i_reg_rdata(reg_rdata), .i_access_err(aerr),
		.o_cmd_wr_valid(wr_v), .o_cmd_wr_addr(wr_a), .o_cmd_wr_data(wr_d), .o_active(active),
		.o_sys_wake(sys_wake), .o_link_fault(fault));
	chain_reg_source src_u (.i_reg_addr(reg_addr), .i_err_mode(err_mode),
		.o_reg_rdata(reg_rdata), .o_access_err(aerr));
	// ----------------------------------------
	// monitor: collects messages, writes and wakes
	// ----------------------------------------
	always @(posedge clk) begin
		if (tx_open) begin
			cur_n = 0;
			cur_w = '0;
		end
		if (tx_bv) begin
			cur_w = {cur_w[126:0], tx_bit};
			cur_n++;
		end
		if (tx_close) begin
			mlen.push_back(cur_n);
			mdat.push_back(cur_w);
			mport.push_back(tx_port);
		end
		if (wr_v) wr_n++;
		if (sys_wake) wake_n++;
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
			err_total++;
		end
	endtask
	// one avalon access held until answered
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk);
		rd <= !w;
		wr <= w;
		addr <= a;
		wdata <= d;
		do begin
			@(posedge clk);
			k++;
		end while (wreq !== 1'b0);
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		chk("wait cycles", 32'd2, k);
	endtask
	function automatic logic [15:0] crc16(input logic [47:0] v);
		logic [15:0] c;
		c = 16'h0000;
		for (int i = 47; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ v[i]) ? `CRC_POLY : 16'h0);
		return c;
	endfunction
	function automatic logic [47:0] hdr(input logic [1:0] c, input logic ld, input logic [2:0] ch,
		input logic [5:0] nd, input logic [3:0] sq, input logic [13:0] rg, input logic [15:0] dw);
		return {c, ld, ch, nd, sq, 2'h0, rg, dw};
	endfunction
	// one 64-bit frame, then wait for an idle transmitter
	task automatic send(input logic [47:0] b, input logic bad);
		logic [63:0] f;
		f = {b, crc16(b) ^ {15'h0, bad}};
		@(posedge clk);
		rx_act <= 1'b1;
		rx_open <= 1'b1;
		for (int i = 63; i >= 0; i--) begin
			@(posedge clk);
			rx_open <= 1'b0;
			rx_bv <= 1'b1;
			rx_bit <= f[i];
		end
		@(posedge clk);
		rx_bv <= 1'b0;
		rx_close <= 1'b1;
		@(posedge clk);
		rx_close <= 1'b0;
		rx_act <= 1'b0;
		do begin
			bus(1'b0, `OFS_STAT, 32'h0);
		end while (q[4] !== 1'b0);
	endtask
	task automatic t_reset;
		bus(1'b0, `OFS_CTRL, 32'h0);
		chk("ctrl reset", `CTRL_RST, q);
		bus(1'b0, `OFS_ERRCNT, 32'h0);
		chk("errcnt reset", 32'h0, q);
		bus(1'b1, 4'hc, 32'hffff_ffff);
		bus(1'b0, 4'hc, 32'h0);
		chk("unmapped read", 32'h0, q);
		$display("test reset done");
	endtask
	task automatic t_write;
		bus(1'b1, `OFS_CTRL, 32'h5);
		send(hdr(`CMD_WR, 1'b0, 3'h1, 6'h05, 4'h2, 14'h0123, 16'habcd), 1'b0);
		chk("write taken", 1, wr_n);
		chk("write addr", 32'h0123, {18'h0, wr_a});
		chk("write data", 32'habcd, {16'h0, wr_d});
		chk("awake", 1, {31'h0, active});
		send(hdr(`CMD_WR, 1'b0, 3'h1, 6'h06, 4'h2, 14'h0123, 16'h1111), 1'b0);
		chk("other node", 1, wr_n);
		send(hdr(`CMD_WR, 1'b0, 3'h1, `NODE_BCAST, 4'h2, 14'h0124, 16'h2222), 1'b0);
		chk("broadcast write", 2, wr_n);
		send(hdr(`CMD_WR, 1'b0, 3'h1, 6'h05, 4'h2, 14'h0125, 16'h3333), 1'b1);
		chk("bad frame dropped", 2, wr_n);
		bus(1'b0, `OFS_STAT, 32'h0);
		chk("fault flags", 32'h7, q);
		bus(1'b0, `OFS_ERRCNT, 32'h0);
		chk("error count", 32'h1, q);
		chk("fault pin", 1, {31'h0, fault});
		bus(1'b1, `OFS_STAT, 32'h3);
		bus(1'b1, `OFS_ERRCNT, 32'h0);
		bus(1'b0, `OFS_STAT, 32'h0);
		chk("flags cleared", 32'h4, q);
		$display("test write and checksum done");
	endtask
	task automatic t_wake(input logic [31:0] ctrl);
		bus(1'b1, `OFS_CTRL, ctrl);
		@(posedge clk);
		chk("asleep", 0, {31'h0, active});
		n0 = mlen.size();
		wake_n = 0;
		send(hdr(`CMD_NOP, 1'b1, 3'h2, `NODE_BCAST, 4'h5, 14'h0a5a, `WAKE_WORD), 1'b0);
		chk("system wake", 1, wake_n);
		send(hdr(`CMD_NOP, 1'b0, 3'h6, `NODE_BCAST, 4'h0, 14'h0000, `WAKE_WORD), 1'b0);
		send(hdr(`CMD_NOP, 1'b0, 3'h1, 6'h05, 4'h0, 14'h0000, 16'h1234), 1'b0);
		chk("later wake", 1, wake_n);
		if (ctrl[7]) begin
			chk("legacy port", 2'b01, mport[n0]);
			chk("legacy bits", 0, mlen[n0]);
			n0++;
		end
		chk("wake bits", 64, mlen[n0]);
		chk("wake top", 32'h1fff_ffff, mdat[n0][63:32]);
		chk("wake low", 32'hffee_7ef4, mdat[n0][31:0]);
		$display("test wake done");
	endtask
	task automatic t_multi(input logic pad, input logic err);
		logic [127:0] t;
		int nw;
		bus(1'b1, `OFS_CTRL, {25'h0, pad, 6'h05});
		err_mode <= err;
		n0 = mlen.size();
		send(hdr(`CMD_RD, 1'b0, 3'h1, 6'h05, 4'h3, 14'h0010, 16'h0105), 1'b0);
		chk("reply count", n0 + 3, mlen.size());
		for (int m = 0; m < 3; m++) begin
			nw = (m == 2 && !pad) ? 1 : 2;
			chk("reply bits", 48 + 16 * nw, mlen[n0 + m]);
			t = mdat[n0 + m] >> (16 * nw + 16);
			chk("reply len", nw - 1, t[15:14]);
			chk("reply head", {3'h1, 6'h05, 4'h3, 2'(nw - 1), 14'h0010 + 14'(2 * m)}, t[28:0]);
			for (int k = 0; k < nw; k++) begin
				t = mdat[n0 + m] >> (16 * (nw - k));
				chk("reply word", (2 * m + k < 5) ? {2'h2, 14'h0010 + 14'(2 * m + k)} :
					(err ? `FILL_ERR : `FILL_OK), t[15:0]);
			end
		end
		err_mode <= 1'b0;
		send(hdr(`CMD_RD, 1'b0, 3'h1, `NODE_BCAST, 4'h3, 14'h0010, 16'h0101), 1'b0);
		chk("broadcast read", n0 + 3, mlen.size());
		$display("test multiread done");
	endtask
	task automatic conclude;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		{rst_n, rd, wr, rx_act, rx_open, rx_bv, rx_bit, rx_close, err_mode} = '0;
		addr = 4'h0;
		wdata = 32'h0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		t_reset;
		t_write;
		t_wake(32'h205);
		t_wake(32'h285);
		t_multi(1'b0, 1'b0);
		t_multi(1'b1, 1'b1);
		conclude;
	end
	// hang guard, well above the run time
	initial begin
		repeat (60000) @(posedge clk);
		err_total++;
		$display("[FAIL] run time expected done seen timeout");
		conclude;
	end
endmodule
